// [design/sdp_regs.v]
`timescale 1ns/10ps
`include "sdp_defines.vh"
module sdp_regs (
  // clock and reset
  input  wire        REF_CLK,
  input  wire        RST,
  // special-function register access
  input  wire [7:0]  SFR_ADDR,
  input  wire        SFR_WR,
  input  wire        SFR_RD,
  input  wire [7:0]  SFR_WDATA,
  output reg  [7:0]  SFR_RDATA,
  output reg         SFR_HIT,
  // stack operations
  input  wire        STK_PUSH,
  input  wire        STK_POP,
  output wire [7:0]  STK_PTR,
  output wire [7:0]  STK_PUSH_ADDR,
  // data pointer operations
  input  wire        PTR_LOAD,
  input  wire [15:0] PTR_LOAD_DATA,
  input  wire        PTR_INC,
  output wire [15:0] ACTIVE_DATA_POINTER,
  output wire        PTR_SEL
);
  wire [7:0] stack_pointer;
  wire [7:0] data_ptr_low_primary;
  wire [7:0] data_ptr_high_primary;
  wire [7:0] data_ptr_low_auxiliary;
  wire [7:0] data_ptr_high_auxiliary;
  reg        choice;
  reg  [7:0] next_rdata;
  reg        next_hit;

  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  wire wr_stack    = SFR_WR && hit(SFR_ADDR, `SDP_ADDR_STACK);
  wire wr_low_pri  = SFR_WR && hit(SFR_ADDR, `SDP_ADDR_DPL_PRI);
  wire wr_high_pri = SFR_WR && hit(SFR_ADDR, `SDP_ADDR_DPH_PRI);
  wire wr_low_aux  = SFR_WR && hit(SFR_ADDR, `SDP_ADDR_DPL_AUX);
  wire wr_high_aux = SFR_WR && hit(SFR_ADDR, `SDP_ADDR_DPH_AUX);
  wire wr_choice   = SFR_WR && hit(SFR_ADDR, `SDP_ADDR_CHOICE);

  sdp_stack_ctr u_stack (
    .REF_CLK   (REF_CLK),
    .RST       (RST),
    .load      (wr_stack),
    .load_data (SFR_WDATA),
    .push      (STK_PUSH),
    .pop       (STK_POP),
    .value     (stack_pointer),
    .push_addr (STK_PUSH_ADDR)
  );

  // sequencer updates reach only the selected pair
  sdp_ptr_pair u_primary (
    .REF_CLK   (REF_CLK),
    .RST       (RST),
    .wr_low    (wr_low_pri),
    .wr_high   (wr_high_pri),
    .wr_data   (SFR_WDATA),
    .load_word (PTR_LOAD && !choice),
    .word_data (PTR_LOAD_DATA),
    .incr      (PTR_INC && !choice),
    .low       (data_ptr_low_primary),
    .high      (data_ptr_high_primary)
  );

  sdp_ptr_pair u_auxiliary (
    .REF_CLK   (REF_CLK),
    .RST       (RST),
    .wr_low    (wr_low_aux),
    .wr_high   (wr_high_aux),
    .wr_data   (SFR_WDATA),
    .load_word (PTR_LOAD && choice),
    .word_data (PTR_LOAD_DATA),
    .incr      (PTR_INC && choice),
    .low       (data_ptr_low_auxiliary),
    .high      (data_ptr_high_auxiliary)
  );

  always @(posedge REF_CLK) begin
    if (RST) begin
      choice <= `SDP_RST_CHOICE;
    end else if (wr_choice) begin
      choice <= SFR_WDATA[`SDP_CHOICE_BIT];
    end
  end

  assign STK_PTR  = stack_pointer;
  assign PTR_SEL  = choice;
  // indirect address for non-scratchpad data memory
  assign ACTIVE_DATA_POINTER = choice ? {data_ptr_high_auxiliary, data_ptr_low_auxiliary}
                                      : {data_ptr_high_primary, data_ptr_low_primary};

  always @* begin
    next_rdata = `SDP_RST_BYTE;
    next_hit   = 1'b1;
    if (hit(SFR_ADDR, `SDP_ADDR_STACK)) begin
      next_rdata = stack_pointer;
    end else if (hit(SFR_ADDR, `SDP_ADDR_DPL_PRI)) begin
      next_rdata = data_ptr_low_primary;
    end else if (hit(SFR_ADDR, `SDP_ADDR_DPH_PRI)) begin
      next_rdata = data_ptr_high_primary;
    end else if (hit(SFR_ADDR, `SDP_ADDR_DPL_AUX)) begin
      next_rdata = data_ptr_low_auxiliary;
    end else if (hit(SFR_ADDR, `SDP_ADDR_DPH_AUX)) begin
      next_rdata = data_ptr_high_auxiliary;
    end else if (hit(SFR_ADDR, `SDP_ADDR_CHOICE)) begin
      next_rdata = {`SDP_ZERO7, choice};
    end else begin
      next_hit = 1'b0;
    end
  end

  // registered read data, one cycle after the strobe
  always @(posedge REF_CLK) begin
    if (RST) begin
      SFR_RDATA <= `SDP_RST_BYTE;
      SFR_HIT   <= 1'b0;
    end else if (SFR_RD) begin
      SFR_RDATA <= next_rdata;
      SFR_HIT   <= next_hit;
    end else begin
      SFR_HIT   <= 1'b0;
    end
  end
endmodule // sdp_regs

// [design/sdp_defines.vh]
`ifndef SDP_DEFINES_VH
`define SDP_DEFINES_VH
// register offsets in the special-function space
`define SDP_ADDR_STACK     8'h81
`define SDP_ADDR_DPL_PRI   8'h82
`define SDP_ADDR_DPH_PRI   8'h83
`define SDP_ADDR_DPL_AUX   8'h84
`define SDP_ADDR_DPH_AUX   8'h85
`define SDP_ADDR_CHOICE    8'h86
// reset values
`define SDP_RST_STACK      8'h07
`define SDP_RST_BYTE       8'h00
`define SDP_RST_CHOICE     1'b0
// field position and constants
`define SDP_CHOICE_BIT     0
`define SDP_BYTE_ONE       8'h01
`define SDP_WORD_ONE       16'h0001
`define SDP_ZERO7          7'h00
`endif

// [design/sdp_stack_ctr.v]
`timescale 1ns/10ps
`include "sdp_defines.vh"
module sdp_stack_ctr (
  // clock and reset
  input  wire       REF_CLK,
  input  wire       RST,
  // software load
  input  wire       load,
  input  wire [7:0] load_data,
  // sequencer strobes
  input  wire       push,
  input  wire       pop,
  // state
  output reg  [7:0] value,
  output wire [7:0] push_addr
);
  reg [7:0] next_value;

  // push writes to the pre-incremented location
  assign push_addr = value + `SDP_BYTE_ONE;

  always @* begin
    next_value = value;
    if (load) begin
      next_value = load_data;
    end else if (push && !pop) begin
      next_value = value + `SDP_BYTE_ONE;
    end else if (pop && !push) begin
      next_value = value - `SDP_BYTE_ONE;
    end
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      value <= `SDP_RST_STACK;
    end else begin
      value <= next_value;
    end
  end
endmodule // sdp_stack_ctr

// [design/sdp_ptr_pair.v]
`timescale 1ns/10ps
`include "sdp_defines.vh"
module sdp_ptr_pair (
  // clock and reset
  input  wire        REF_CLK,
  input  wire        RST,
  // byte writes
  input  wire        wr_low,
  input  wire        wr_high,
  input  wire [7:0]  wr_data,
  // whole-word update from the sequencer
  input  wire        load_word,
  input  wire [15:0] word_data,
  input  wire        incr,
  // state
  output reg  [7:0]  low,
  output reg  [7:0]  high
);
  wire [15:0] word;
  wire [15:0] word_inc;
  assign word     = {high, low};
  assign word_inc = word + `SDP_WORD_ONE;

  always @(posedge REF_CLK) begin
    if (RST) begin
      low  <= `SDP_RST_BYTE;
      high <= `SDP_RST_BYTE;
    end else if (load_word) begin
      low  <= word_data[7:0];
      high <= word_data[15:8];
    end else if (incr) begin
      low  <= word_inc[7:0];
      high <= word_inc[15:8];
    end else begin
      if (wr_low) begin
        low <= wr_data;
      end
      if (wr_high) begin
        high <= wr_data;
      end
    end
  end
endmodule // sdp_ptr_pair

// [testbench/sdp_seq_model.sv]
`timescale 1ns/10ps
module sdp_seq_model (
  // sequencer op code in, strobes out
  input  wire logic       REF_CLK,
  input  wire logic [1:0] op,
  output logic            push,
  output logic            pop
);
  initial begin
    push = 1'b0;
    pop  = 1'b0;
  end
  // op 3 raises both strobes together
  always @(posedge REF_CLK) begin
    push <= op[0];
    pop  <= op[1];
  end
endmodule // sdp_seq_model

// [testbench/sdp_regs_asserts.sv]
`timescale 1ns/10ps
module sdp_regs_chk (
  input wire logic REF_CLK, RST, SFR_WR, SFR_RD, SFR_HIT, STK_PUSH, STK_POP, PTR_LOAD, PTR_INC, PTR_SEL,
  input wire logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, STK_PTR, STK_PUSH_ADDR,
  input wire logic [15:0] PTR_LOAD_DATA, ACTIVE_DATA_POINTER
);
  default clocking @(posedge REF_CLK); endclocking
  wire stk_wr = SFR_WR && SFR_ADDR == 8'h81;
  wire mapped = SFR_ADDR >= 8'h81 && SFR_ADDR <= 8'h86;
  sequence push_s; STK_PUSH && !STK_POP && !stk_wr; endsequence
  sequence pop_s; STK_POP && !STK_PUSH && !stk_wr; endsequence
  stack_reset_a: assert property (RST |=> STK_PTR == 8'h07 && ACTIVE_DATA_POINTER == 16'h0000)
    else $error("reset values wrong");
  stack_load_a: assert property (disable iff (RST) stk_wr |=> STK_PTR == $past(SFR_WDATA))
    else $error("stack load lost");
  push_addr_a: assert property (disable iff (RST) STK_PUSH_ADDR == STK_PTR + 8'h01)
    else $error("push address wrong");
  push_inc_a: assert property (disable iff (RST) push_s |=> STK_PTR == $past(STK_PTR) + 8'h01)
    else $error("push step wrong");
  pop_dec_a: assert property (disable iff (RST) pop_s |=> STK_PTR == $past(STK_PTR) - 8'h01)
    else $error("pop step wrong");
  sel_write_a: assert property (disable iff (RST) SFR_WR && SFR_ADDR == 8'h86 |=> PTR_SEL == $past(SFR_WDATA[0]))
    else $error("choice bit wrong");
  choice_read_a: assert property (disable iff (RST) SFR_RD && SFR_ADDR == 8'h86 |=> SFR_RDATA[7:1] == 7'h00)
    else $error("choice upper bits set");
  unmapped_read_a: assert property (disable iff (RST) SFR_RD && !mapped |=> !SFR_HIT && SFR_RDATA == 8'h00)
    else $error("unmapped read answered");
  ptr_hold_a: assert property (disable iff (RST) !PTR_LOAD && !PTR_INC && !SFR_WR |=> $stable(ACTIVE_DATA_POINTER))
    else $error("pointer moved");
  ptr_load_a: assert property (disable iff (RST) PTR_LOAD && !SFR_WR |=> ACTIVE_DATA_POINTER == $past(PTR_LOAD_DATA))
    else $error("pointer load lost");
endmodule // sdp_regs_chk
bind sdp_regs sdp_regs_chk chk (.*);

// [testbench/tb.sv]
`timescale 1ns/10ps
module tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, ld = 0, inc = 0, push, pop, hit, sel;
  logic [1:0] op = 0;
  logic [7:0] adr = 0, wd = 0, rdat, stk, padr;
  logic [15:0] ldd = 0, act;
  integer seed = 32'h7042d807, num_errors = 0, checked = 0, cyc = 0, p, i, m_sp, m_rd, m_hit, m_sel, m_dp[2];
  always #25 clk = ~clk;
  sdp_seq_model sq (.REF_CLK(clk), .op(op), .push(push), .pop(pop));
  sdp_regs uut (.REF_CLK(clk), .RST(rst), .SFR_ADDR(adr), .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wd),
    .SFR_RDATA(rdat), .SFR_HIT(hit), .STK_PUSH(push), .STK_POP(pop), .STK_PTR(stk), .STK_PUSH_ADDR(padr),
    .PTR_LOAD(ld), .PTR_LOAD_DATA(ldd), .PTR_INC(inc), .ACTIVE_DATA_POINTER(act), .PTR_SEL(sel));
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  task test_done;
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task run(input integer n);
    repeat (n) @(posedge clk) begin
      adr <= 8'h80 + {$random(seed)} % 8;
      wr <= $random(seed);
      rd <= $random(seed);
      wd <= $random(seed);
      ld <= $random(seed);
      inc <= $random(seed);
      ldd <= $random(seed);
      op <= $random(seed);
    end
  endtask
  // reference model of the register file
  always @(posedge clk) begin
    p = (adr - 130) / 2;
    if (rst) begin
      m_sp = 7; m_dp[0] = 0; m_dp[1] = 0; m_sel = 0; m_rd = 0; m_hit = 0;
    end else begin
      m_hit = rd && adr >= 8'h81 && adr <= 8'h86;
      if (rd) m_rd = !m_hit ? 0 : adr == 8'h81 ? m_sp : adr == 8'h86 ? m_sel : (m_dp[p] >> (adr[0] * 8)) % 256;
      if (wr && adr == 8'h81) m_sp = wd;
      else if (push && !pop) m_sp = (m_sp + 1) % 256;
      else if (pop && !push) m_sp = (m_sp + 255) % 256;
      for (i = 0; i < 2; i++) begin
        if (ld && m_sel == i) m_dp[i] = ldd;
        else if (inc && m_sel == i) m_dp[i] = (m_dp[i] + 1) % 65536;
        else if (wr && p == i) m_dp[i] = adr[0] ? m_dp[i] % 256 + wd * 256 : m_dp[i] - m_dp[i] % 256 + wd;
      end
      if (wr && adr == 8'h86) m_sel = wd[0];
    end
    cyc = cyc + 1;
    if (cyc > 6000) begin
      num_errors++;
      test_done;
    end
  end
  always @(negedge clk) if (cyc > 1) begin
    chk("stack", stk, m_sp);
    chk("push_addr", padr, (m_sp + 1) % 256);
    chk("pointer", act, m_dp[m_sel]);
    chk("choice", sel, m_sel);
    chk("rdata", rdat, m_rd);
    chk("hit", hit, m_hit);
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    @(negedge clk);
    chk("reset_stack", stk, 16'h0007);
    chk("reset_ptr", act, 16'h0000);
    $display("test reset done");
    run(3000);
    $display("test random done");
    rst <= 1;
    run(4);
    rst <= 0;
    run(1000);
    $display("test midrun reset done");
    test_done;
  end
endmodule // tb
